// *** core/fls_supervisor.sv ***
// Operation
// (RQ1) mode select 1 enters fieldbus control
// (RQ2) fieldbus mode forces frequency source 10
// (RQ3) fieldbus mode ignores reverse inhibit
// (RQ4) fieldbus entry defaults direction forward
// (RQ5) fieldbus mode: commands only from link
// (RQ6) mode select 0 leaves fieldbus control
// (RQ7) mode change acts only after restart
// (RQ8) action 1: show code, reset key ignored
// (RQ9) action 1: fault latched until manual reset
// (RQ10) action 2: fault clears on reconnect
// (RQ11) zero delay: protect at once
// (RQ12) nonzero delay: wait, then protect
// (RQ13) lamp flashes while link not lost
// (RQ14) link loss raises distinct fault
// (RQ15) restore during delay cancels pending protection
//
// The address map and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module fls_supervisor
  import fls_pkg::*;
#(
  parameter int DelayTickCycles = DELAY_TICK_CYCLES,
  parameter int LedHalfCycles = LED_HALF_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // stored mode setting and identity words
  input wire logic storedModeSel,
  input wire logic [15:0] stationHwAddrLow,
  output logic modeSelectStore,
  // fieldbus side
  input wire logic linkUp,
  input wire fls_cmd_t fbCmd,
  // local keypad and terminals
  input wire fls_cmd_t localCmd,
  input wire logic keypadResetKey,
  input wire logic [3:0] localFreqSource,
  input wire logic localReverseInhibit,
  // drive command path and indication
  output fls_cmd_t driveCmd,
  output logic [3:0] mainFreqSource,
  output logic reverseInhibitEff,
  output logic linkLostFault,
  output logic linkLostDisplay,
  output logic linkStatusLed,
  output logic irq
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // only settings 1 and 2 arm the protection
  function automatic logic actionArmed(input logic [1:0] act);
    actionArmed = (act == ACTION_LATCH) || (act == ACTION_AUTO);
  endfunction

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  logic [7:0] wrAddr_reg, wrAddr_next;
  logic wrPend_reg, wrPend_next;
  logic [7:0] rdAddr_reg, rdAddr_next;
  logic rdPend_reg, rdPend_next;
  logic hreadyout_reg, hreadyout_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic modePend_reg, modePend_next;
  logic [1:0] offlineAction_reg, offlineAction_next;
  logic [15:0] offlineDelay_reg, offlineDelay_next;
  logic [NUM_EVENTS-1:0] irqStatus_reg, irqStatus_next;
  logic [NUM_EVENTS-1:0] irqEnable_reg, irqEnable_next;
  logic [NUM_EVENTS-1:0] irqClear, events;
  logic activeMode_reg, activeMode_next;
  logic captured_reg, captured_next;
  fls_sup_state_t state_reg, state_next;
  logic linkPrev_reg, linkPrev_next;

  logic addrPhase;
  assign addrPhase = hsel && htrans[1] && hready;

  // address phase capture; reads get one wait state so a write just before is seen
  always_comb begin
    wrPend_next = addrPhase && hwrite;
    wrAddr_next = addrPhase ? haddr[7:0] : wrAddr_reg;
    rdPend_next = addrPhase && !hwrite;
    rdAddr_next = addrPhase ? haddr[7:0] : rdAddr_reg;
    hreadyout_next = !(addrPhase && !hwrite);
    hrdata_next = hrdata_reg;
    if (rdPend_reg) begin
      case (rdAddr_reg)
        OFS_MODE_CFG: hrdata_next = {31'h0, modePend_reg};
        OFS_OFFLINE_ACTION: hrdata_next = {30'h0, offlineAction_reg};
        OFS_OFFLINE_DELAY: hrdata_next = {16'h0, offlineDelay_reg};
        OFS_STATUS: hrdata_next = {24'h0, state_reg, linkUp, linkLostFault, captured_reg, activeMode_reg};
        OFS_IRQ_STATUS: hrdata_next = {28'h0, irqStatus_reg};
        OFS_IRQ_ENABLE: hrdata_next = {28'h0, irqEnable_reg};
        OFS_STATION_HW_ADDR_LOW: hrdata_next = {16'h0, stationHwAddrLow};
        OFS_COMM_FW_VERSION_HIGH: hrdata_next = {16'h0, RST_FW_VERSION};
        OFS_COMM_FW_VERSION_LOW: hrdata_next = {16'h0, RST_FW_VERSION};
        default: hrdata_next = 32'h0000_0000; // unmapped and write-only read zero
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 8'h00;
      rdPend_reg <= 1'b0;
      rdAddr_reg <= 8'h00;
      hreadyout_reg <= 1'b1;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      wrPend_reg <= wrPend_next;
      wrAddr_reg <= wrAddr_next;
      rdPend_reg <= rdPend_next;
      rdAddr_reg <= rdAddr_next;
      hreadyout_reg <= hreadyout_next;
      hrdata_reg <= hrdata_next;
    end
  end

  // ----------------------------------------
  // configuration registers and mode capture
  // ----------------------------------------
  // the active mode is caught once after reset release; later writes only
  // update the stored copy, which is why a restart is needed
  always_comb begin
    modePend_next = modePend_reg;
    offlineAction_next = offlineAction_reg;
    offlineDelay_next = offlineDelay_reg;
    irqEnable_next = irqEnable_reg;
    irqClear = '0;
    captured_next = 1'b1;
    activeMode_next = activeMode_reg;
    if (!captured_reg) begin
      activeMode_next = storedModeSel; // RQ7
      modePend_next = storedModeSel;
    end else if (wrPend_reg) begin
      case (wrAddr_reg)
        OFS_MODE_CFG: modePend_next = hwdata[0]; // RQ1 RQ6 RQ7
        OFS_OFFLINE_ACTION: offlineAction_next = hwdata[1:0];
        OFS_OFFLINE_DELAY: offlineDelay_next = hwdata[15:0];
        OFS_IRQ_CLEAR: irqClear = hwdata[NUM_EVENTS-1:0];
        OFS_IRQ_ENABLE: irqEnable_next = hwdata[NUM_EVENTS-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      captured_reg <= 1'b0;
      activeMode_reg <= 1'b0;
      modePend_reg <= 1'b0;
      offlineAction_reg <= RST_OFFLINE_ACTION;
      offlineDelay_reg <= RST_OFFLINE_DELAY;
      irqEnable_reg <= '0;
    end else begin
      captured_reg <= captured_next;
      activeMode_reg <= activeMode_next;
      modePend_reg <= modePend_next;
      offlineAction_reg <= offlineAction_next;
      offlineDelay_reg <= offlineDelay_next;
      irqEnable_reg <= irqEnable_next;
    end
  end

  // ----------------------------------------
  // link-loss supervision
  // ----------------------------------------
  logic [31:0] tickCnt_reg, tickCnt_next;
  logic [15:0] unitCnt_reg, unitCnt_next;
  logic delayDone;
  assign delayDone = (unitCnt_reg == offlineDelay_reg);

  always_comb begin
    state_next = state_reg;
    tickCnt_next = 32'h0000_0000;
    unitCnt_next = 16'h0000;
    case (state_reg)
      SUP_OK: begin
        if (activeMode_reg && !linkUp && actionArmed(offlineAction_reg)) begin
          state_next = (offlineDelay_reg == 16'h0000) ? SUP_FAULT : SUP_WAIT; // RQ11 RQ12 RQ14
        end
      end
      SUP_WAIT: begin
        if (linkUp) begin
          state_next = SUP_OK; // RQ15
        end else if (delayDone) begin
          state_next = SUP_FAULT; // RQ12
        end else if (tickCnt_reg == 32'(DelayTickCycles - 1)) begin
          unitCnt_next = unitCnt_reg + 16'h0001;
        end else begin
          tickCnt_next = tickCnt_reg + 32'h0000_0001;
          unitCnt_next = unitCnt_reg;
        end
      end
      SUP_FAULT: begin
        // reset key ignored while the link is down
        if (linkUp) begin
          state_next = (offlineAction_reg == ACTION_AUTO) ? SUP_OK : SUP_HELD; // RQ8 RQ9 RQ10
        end
      end
      SUP_HELD: begin
        if (!linkUp) begin
          state_next = SUP_FAULT;
        end else if (keypadResetKey) begin
          state_next = SUP_OK; // RQ9
        end
      end
      default: state_next = SUP_OK;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= SUP_OK;
      tickCnt_reg <= 32'h0000_0000;
      unitCnt_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      tickCnt_reg <= tickCnt_next;
      unitCnt_reg <= unitCnt_next;
    end
  end

  // ----------------------------------------
  // command path and indication
  // ----------------------------------------
  logic [31:0] ledCnt_reg, ledCnt_next;
  logic ledOn_reg, ledOn_next;
  logic faultNow;
  fls_cmd_t driveCmd_reg, driveCmd_next;
  logic [3:0] freqSrc_reg, freqSrc_next;
  logic revInh_reg, revInh_next;
  logic fault_reg, fault_next;

  assign faultNow = (state_next == SUP_FAULT) || (state_next == SUP_HELD);

  // a fault forces stop; direction is forward until the mode is captured, then from the link, or from the local command forced forward by reverse inhibit
  always_comb begin
    fault_next = faultNow; // RQ14
    freqSrc_next = activeMode_reg ? FREQ_SRC_FIELDBUS : localFreqSource; // RQ2
    revInh_next = activeMode_reg ? 1'b0 : localReverseInhibit; // RQ3
    driveCmd_next = activeMode_reg ? fbCmd : localCmd; // RQ5
    if (!captured_reg) begin
      driveCmd_next = '0; // RQ4
    end
    if (!activeMode_reg && localReverseInhibit) begin
      driveCmd_next.reverse = 1'b0;
    end
    if (faultNow) begin
      driveCmd_next.start = 1'b0;
      driveCmd_next.stop = 1'b1;
    end
    ledCnt_next = ledCnt_reg + 32'h0000_0001;
    ledOn_next = ledOn_reg;
    if (!linkUp) begin
      ledCnt_next = 32'h0000_0000;
      ledOn_next = 1'b0;
    end else if (ledCnt_reg == 32'(LedHalfCycles - 1)) begin
      ledCnt_next = 32'h0000_0000;
      ledOn_next = !ledOn_reg; // RQ13
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_reg <= 1'b0;
      freqSrc_reg <= 4'h0;
      revInh_reg <= 1'b0;
      driveCmd_reg <= '0;
      ledCnt_reg <= 32'h0000_0000;
      ledOn_reg <= 1'b0;
    end else begin
      fault_reg <= fault_next;
      freqSrc_reg <= freqSrc_next;
      revInh_reg <= revInh_next;
      driveCmd_reg <= driveCmd_next;
      ledCnt_reg <= ledCnt_next;
      ledOn_reg <= ledOn_next;
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  logic irq_reg, irq_next;
  always_comb begin
    linkPrev_next = linkUp;
    events = '0;
    events[EV_FAULT_SET] = faultNow && !fault_reg;
    events[EV_FAULT_CLR] = !faultNow && fault_reg;
    events[EV_LINK_LOST] = linkPrev_reg && !linkUp;
    events[EV_LINK_BACK] = !linkPrev_reg && linkUp;
    irq_next = |(irqStatus_next & irqEnable_next);
  end

  // set beats clear in the same cycle so no event is lost
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EVENTS; gi++) begin : gIrq
      assign irqStatus_next[gi] = events[gi] || (irqStatus_reg[gi] && !irqClear[gi]);
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irqStatus_reg <= '0;
      irq_reg <= 1'b0;
      linkPrev_reg <= 1'b1; // idle link is up, so no false link-back edge after reset
    end else begin
      irqStatus_reg <= irqStatus_next;
      irq_reg <= irq_next;
      linkPrev_reg <= linkPrev_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = 1'b0; // always okay
  assign modeSelectStore = modePend_reg;
  assign driveCmd = driveCmd_reg;
  assign mainFreqSource = freqSrc_reg;
  assign reverseInhibitEff = revInh_reg;
  assign linkLostFault = fault_reg;
  assign linkLostDisplay = fault_reg; // RQ8 RQ10
  assign linkStatusLed = ledOn_reg;
  assign irq = irq_reg;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_mode_frozen: assert property (captured_reg && $past(captured_reg) |-> $stable(activeMode_reg)) // RQ7
    else $error("active mode changed without restart");
  a_src_forced: assert property (activeMode_reg |=> mainFreqSource == FREQ_SRC_FIELDBUS) // RQ2
    else $error("frequency source not forced");
  a_rev_allowed: assert property (activeMode_reg |=> !reverseInhibitEff) // RQ3
    else $error("reverse inhibit active in fieldbus mode");
  a_cmd_from_link: assert property (activeMode_reg && !faultNow |=> driveCmd == $past(fbCmd)) // RQ5 RQ1
    else $error("command not taken from link");
  a_cmd_local: assert property (!activeMode_reg && captured_reg && !localReverseInhibit
                                |=> driveCmd == $past(localCmd)) // RQ6
    else $error("local command not passed");
  a_zero_delay: assert property (state_reg == SUP_OK && activeMode_reg && !linkUp
                                 && actionArmed(offlineAction_reg) && offlineDelay_reg == 16'h0000
                                 |=> linkLostFault) // RQ11 RQ14
    else $error("no immediate fault at zero delay");
  a_delay_wait: assert property (state_reg == SUP_WAIT && !delayDone |=> !linkLostFault) // RQ12
    else $error("fault before delay ran out");
  a_cancel_wait: assert property (state_reg == SUP_WAIT && linkUp |=> state_reg == SUP_OK) // RQ15
    else $error("pending protection not cancelled");
  a_key_ignored: assert property (state_reg == SUP_FAULT && !linkUp |=> linkLostFault) // RQ8
    else $error("fault left while link down");
  a_latch_held: assert property (state_reg == SUP_HELD && linkUp && !keypadResetKey |=> linkLostFault) // RQ9
    else $error("latched fault cleared without key");
  a_auto_clear: assert property (state_reg == SUP_FAULT && linkUp && offlineAction_reg == ACTION_AUTO
                                 |=> !linkLostFault) // RQ10
    else $error("fault not cleared on reconnect");
  a_led_dark: assert property (!linkUp |=> !linkStatusLed) // RQ13
    else $error("lamp lit while link lost");
  a_fwd_start: assert property ($rose(captured_reg) |-> !driveCmd.reverse) // RQ4
    else $error("not forward after mode entry");

  c_fault_latch: cover property (state_reg == SUP_FAULT ##1 state_reg == SUP_HELD ##[1:20] state_reg == SUP_OK);
  c_delay_run: cover property (state_reg == SUP_WAIT ##1 state_reg == SUP_FAULT);
  c_cancel: cover property (state_reg == SUP_WAIT ##1 state_reg == SUP_OK);

endmodule
`default_nettype wire

// *** core/fls_pkg.sv ***
`default_nettype none
package fls_pkg;

  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int DELAY_UNIT_MS = 100; // one step of the offline delay setting
  localparam int DELAY_TICK_CYCLES = (CLK_HZ / 1000) * DELAY_UNIT_MS;
  localparam int LED_HALF_MS = 250; // status lamp half period
  localparam int LED_HALF_CYCLES = (CLK_HZ / 1000) * LED_HALF_MS;

  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_MODE_CFG = 8'h00;
  localparam logic [7:0] OFS_OFFLINE_ACTION = 8'h04;
  localparam logic [7:0] OFS_OFFLINE_DELAY = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h14;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h18;
  localparam logic [7:0] OFS_STATION_HW_ADDR_LOW = 8'h1C;
  localparam logic [7:0] OFS_COMM_FW_VERSION_HIGH = 8'h20;
  localparam logic [7:0] OFS_COMM_FW_VERSION_LOW = 8'h24;

  // ----------------------------------------
  // field values and reset values
  // ----------------------------------------
  localparam logic [3:0] FREQ_SRC_FIELDBUS = 4'hA;
  localparam logic [1:0] ACTION_LATCH = 2'h1;
  localparam logic [1:0] ACTION_AUTO = 2'h2;
  localparam logic [1:0] RST_OFFLINE_ACTION = 2'h1;
  localparam logic [15:0] RST_OFFLINE_DELAY = 16'h0000;
  localparam logic [15:0] RST_FW_VERSION = 16'h0000;
  localparam int NUM_EVENTS = 4;
  localparam int EV_FAULT_SET = 0;
  localparam int EV_FAULT_CLR = 1;
  localparam int EV_LINK_LOST = 2;
  localparam int EV_LINK_BACK = 3;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [3:0] {
    SUP_OK = 4'b0001,
    SUP_WAIT = 4'b0010,
    SUP_FAULT = 4'b0100,
    SUP_HELD = 4'b1000
  } fls_sup_state_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic reverse;
    logic [15:0] freq;
  } fls_cmd_t;

endpackage
`default_nettype wire

// *** verif/fls_fb_master.sv ***
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// fieldbus master model
// ----------------------------------------
module fls_fb_master
  import fls_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // bench wishes
  input wire logic wantLink,
  input wire fls_cmd_t wantCmd,
  // link towards the drive
  output logic linkUp,
  output fls_cmd_t fbCmd
);
  fls_cmd_t cmdNext;

  // a lost link carries no valid command, so show a changing value
  always_comb begin
    cmdNext = wantLink ? wantCmd : ~fbCmd;
  end

  // link and command change only just after an edge
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      linkUp <= 1'b1;
      fbCmd <= '0;
    end else begin
      linkUp <= wantLink;
      fbCmd <= cmdNext;
    end
  end
endmodule
`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb
  import fls_pkg::*;
;
  // ----------------------------------------
  // bench signals
  // ----------------------------------------
  localparam int LIMIT = 20000;
  logic sys_clk, rst_b, hsel, hwrite, storedModeSel, wantLink, keypadResetKey, localReverseInhibit;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] stationHwAddrLow;
  logic [3:0] localFreqSource, mainFreqSource;
  logic hreadyout, hresp, modeSelectStore, linkUp, reverseInhibitEff;
  logic linkLostFault, linkLostDisplay, linkStatusLed, irq;
  fls_cmd_t wantCmd, fbCmd, localCmd, driveCmd;
  int errorCnt = 0;
  int checksDone = 0;
  int cycles = 0;
  int n;

  fls_supervisor #(.DelayTickCycles(4), .LedHalfCycles(4)) i_fls_supervisor (
    .sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .storedModeSel(storedModeSel),
    .stationHwAddrLow(stationHwAddrLow), .modeSelectStore(modeSelectStore), .linkUp(linkUp),
    .fbCmd(fbCmd), .localCmd(localCmd), .keypadResetKey(keypadResetKey),
    .localFreqSource(localFreqSource), .localReverseInhibit(localReverseInhibit),
    .driveCmd(driveCmd), .mainFreqSource(mainFreqSource), .reverseInhibitEff(reverseInhibitEff),
    .linkLostFault(linkLostFault), .linkLostDisplay(linkLostDisplay),
    .linkStatusLed(linkStatusLed), .irq(irq));

  fls_fb_master i_fls_fb_master (.sys_clk(sys_clk), .rst_b(rst_b), .wantLink(wantLink),
    .wantCmd(wantCmd), .linkUp(linkUp), .fbCmd(fbCmd));

  // 25 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // helper tasks
  // ----------------------------------------
  task automatic finalReport();
    $display("checks %0d mismatches %0d", checksDone, errorCnt);
    if (errorCnt == 0 && checksDone > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      errorCnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask

  // no fixed wait state assumed: only the watchdog ends a hang
  task automatic waitReady();
    do begin
      @(posedge sys_clk);
    end while (hreadyout !== 1'b1);
    chk("bus resp", 32'h0, 32'(hresp));
  endtask

  task automatic busAcc(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    waitReady();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitReady();
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    busAcc(1'b1, a, d);
  endtask

  task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
    busAcc(1'b0, a, 32'h0);
    chk(what, exp, q);
  endtask

  task automatic restart(input logic m);
    storedModeSel <= m;
    rst_b <= 1'b0;
    cyc(2);
    rst_b <= 1'b1;
    cyc(3);
  endtask

  task automatic link(input logic v, input int k);
    wantLink <= v;
    cyc(k);
  endtask

  task automatic pressKey();
    keypadResetKey <= 1'b1;
    cyc(3);
    keypadResetKey <= 1'b0;
    cyc(2);
  endtask

  task automatic waitFault(input int mx);
    n = 0;
    while (linkLostFault !== 1'b1 && n < mx) begin
      @(posedge sys_clk);
      n++;
    end
  endtask

  // a hang counts as a mismatch
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errorCnt++;
      finalReport();
    end
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    {hsel, hwrite, haddr, hwdata, htrans, storedModeSel, keypadResetKey} = '0;
    hsize = 3'h2;
    rst_b = 1'b0;
    stationHwAddrLow = 16'h5A3C;
    wantLink = 1'b1;
    wantCmd = {1'b1, 1'b0, 1'b1, 16'h0BCD};
    localCmd = {1'b1, 1'b0, 1'b1, 16'h1234};
    localFreqSource = 4'h3;
    localReverseInhibit = 1'b1;
    cyc(1);
    chk("cmd in reset", 32'h0, 32'(driveCmd));
    cyc(1);
    rst_b <= 1'b1;
    cyc(3);
    // local mode, register reset values
    rdChk("action", OFS_OFFLINE_ACTION, 32'h1);
    rdChk("delay", OFS_OFFLINE_DELAY, 32'h0);
    rdChk("fw high", OFS_COMM_FW_VERSION_HIGH, 32'h0);
    rdChk("fw low", OFS_COMM_FW_VERSION_LOW, 32'h0);
    rdChk("hw addr", OFS_STATION_HW_ADDR_LOW, 32'h5A3C);
    rdChk("unmapped", 8'h40, 32'h0);
    busAcc(1'b0, OFS_STATUS, 32'h0);
    chk("mode local", 32'h0, 32'(q[0]));
    chk("src local", 32'h3, 32'(mainFreqSource));
    chk("inhibit local", 32'h1, 32'(reverseInhibitEff));
    chk("cmd local", 32'({1'b1, 1'b0, 1'b0, 16'h1234}), 32'(driveCmd));
    localReverseInhibit <= 1'b0;
    cyc(2);
    chk("cmd rev local", 32'({1'b1, 1'b0, 1'b1, 16'h1234}), 32'(driveCmd));
    chk("inhibit clear local", 32'h0, 32'(reverseInhibitEff));
    localReverseInhibit <= 1'b1;
    link(1'b0, 6);
    chk("no fault local", 32'h0, 32'(linkLostFault));
    link(1'b1, 3);
    wr(OFS_MODE_CFG, 32'h1);
    cyc(2);
    chk("mode store", 32'h1, 32'(modeSelectStore));
    rdChk("mode cfg", OFS_MODE_CFG, 32'h1);
    chk("src unchanged", 32'h3, 32'(mainFreqSource));
    // fieldbus mode after restart
    restart(1'b1);
    chk("src bus", 32'hA, 32'(mainFreqSource));
    chk("inhibit off", 32'h0, 32'(reverseInhibitEff));
    chk("cmd bus", 32'(wantCmd), 32'(driveCmd));
    busAcc(1'b0, OFS_STATUS, 32'h0);
    chk("mode bus", 32'h1, 32'(q[0]));
    wr(OFS_MODE_CFG, 32'h0);
    cyc(2);
    chk("src kept", 32'hA, 32'(mainFreqSource));
    begin : led_blk
      logic last;
      int t;
      t = 0;
      last = linkStatusLed;
      repeat (20) begin
        @(posedge sys_clk);
        if (linkStatusLed !== last) t++;
        last = linkStatusLed;
      end
      chk("lamp flashing", 32'h1, 32'(t >= 3));
    end
    // action 1, zero delay, interrupts
    wr(OFS_IRQ_CLEAR, 32'hF);
    wr(OFS_IRQ_ENABLE, 32'h1);
    rdChk("irq enable", OFS_IRQ_ENABLE, 32'h1);
    link(1'b0, 4);
    chk("fault now", 32'h1, 32'(linkLostFault));
    chk("display", 32'h1, 32'(linkLostDisplay));
    chk("stop forced", 32'h1, 32'({driveCmd.start, driveCmd.stop}));
    chk("lamp off", 32'h0, 32'(linkStatusLed));
    chk("irq on", 32'h1, 32'(irq));
    rdChk("irq status", OFS_IRQ_STATUS, 32'h5);
    wr(OFS_IRQ_ENABLE, 32'h0);
    cyc(2);
    chk("irq masked", 32'h0, 32'(irq));
    wr(OFS_IRQ_STATUS, 32'h0);
    rdChk("status ro", OFS_IRQ_STATUS, 32'h5);
    wr(OFS_IRQ_CLEAR, 32'h1);
    wr(OFS_IRQ_ENABLE, 32'h1);
    cyc(2);
    chk("irq cleared", 32'h0, 32'(irq));
    rdChk("status clr", OFS_IRQ_STATUS, 32'h4);
    pressKey();
    chk("key ignored", 32'h1, 32'(linkLostFault));
    link(1'b1, 6);
    chk("latched", 32'h1, 32'(linkLostFault));
    pressKey();
    chk("key clears", 32'h0, 32'(linkLostFault));
    rdChk("irq status all", OFS_IRQ_STATUS, 32'hE);
    // action 2 and delays
    wr(OFS_OFFLINE_ACTION, 32'h2);
    link(1'b0, 4);
    chk("auto fault", 32'h1, 32'(linkLostFault));
    link(1'b1, 4);
    chk("auto clear", 32'h0, 32'(linkLostFault));
    wr(OFS_OFFLINE_DELAY, 32'h2);
    link(1'b0, 6);
    chk("delay wait", 32'h0, 32'(linkLostFault));
    waitFault(30);
    chk("delay fault", 32'h1, 32'(linkLostFault));
    link(1'b1, 4);
    wr(OFS_OFFLINE_DELAY, 32'h3);
    link(1'b0, 10);
    link(1'b1, 24);
    chk("cancelled", 32'h0, 32'(linkLostFault));
    link(1'b0, 12);
    chk("count restart", 32'h0, 32'(linkLostFault));
    waitFault(30);
    chk("late fault", 32'h1, 32'(linkLostFault));
    link(1'b1, 4);
    // action setting 0 arms no protection
    wr(OFS_OFFLINE_ACTION, 32'h0);
    link(1'b0, 6);
    chk("action off", 32'h0, 32'(linkLostFault));
    link(1'b1, 2);
    finalReport();
  end
endmodule
`default_nettype wire
